// ===== hw/odtam_pkg.sv
// Package of constants, types and register layout for the termination mode transition block.
package odtam_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_PERIOD_PS = 10000;
   localparam int ASYNC_ON_MIN_PS = 2000;
   localparam int ASYNC_ON_MAX_PS = 8500;
   localparam int ASYNC_OFF_MIN_PS = 2000;
   localparam int ASYNC_OFF_MAX_PS = 8500;
   // Least rounds up, longest rounds down, never below one cycle
   localparam int ASYNC_MIN_CYC_RAW = (ASYNC_ON_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ASYNC_MAX_CYC_RAW = ASYNC_ON_MAX_PS / CLK_PERIOD_PS;
   localparam int ASYNC_MIN_CYC = (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
   localparam int ASYNC_MAX_CYC = (ASYNC_MAX_CYC_RAW < 1) ? 1 : ASYNC_MAX_CYC_RAW;
   localparam int SYNC_LAT_OFFSET = 2;
   localparam int ENTRY_LEAD_OFFSET = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_LATENCY = 4'h4;
   localparam logic [3:0] REG_TIMING = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hC;

   // CTRL fields
   localparam int CTRL_DLL_ON_BIT = 0;
   localparam int CTRL_FREEZE_SEL_BIT = 1;
   localparam int CTRL_PICK_ASYNC_BIT = 2;
   // LATENCY fields
   localparam int LAT_CWL_LSB = 0;
   localparam int LAT_AL_LSB = 8;
   // TIMING fields
   localparam int TIM_CPDED_LSB = 0;
   localparam int TIM_RFC_LSB = 8;
   localparam int TIM_XPDLL_LSB = 16;
   // STATUS fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_RTT_BIT = 4;
   localparam int STAT_ODT_BIT = 5;
   localparam int STAT_CKE_BIT = 6;
   localparam int STAT_ASYNC_BIT = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic RST_DLL_ON = 1'b1;
   localparam logic RST_FREEZE_SEL = 1'b1;
   localparam logic RST_PICK_ASYNC = 1'b0;
   localparam logic [4:0] RST_CWL = 5'h05;
   localparam logic [4:0] RST_AL = 5'h00;
   localparam logic [7:0] RST_CPDED = 8'h01;
   localparam logic [7:0] RST_RFC = 8'h0B;
   localparam logic [7:0] RST_XPDLL = 8'h0A;
   localparam logic [5:0] MIN_WRITE_LATENCY = 6'h05;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic dll_on_mode;
      logic dll_freeze_select_bit;
      logic pick_async;
      logic [4:0] cas_write_latency;
      logic [4:0] additive_latency;
      logic [7:0] cpded_cycles;
      logic [7:0] rfc_cycles;
      logic [7:0] pd_exit_dll_delay;
   } odtam_cfg_t;

   typedef enum logic [3:0] {
      ST_SYNC = 4'h1,
      ST_ENTRY = 4'h2,
      ST_ASYNC = 4'h4,
      ST_EXIT = 4'h8
   } odtam_state_t;

endpackage

// ===== hw/odtam_delay_line.sv
// Shift line with a selectable tap for the synchronous termination latency.
`timescale 1ns/1ps
module odtam_delay_line import odtam_pkg::*; #(
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Data
   input wire logic bit_in,
   input wire logic [4:0] tap_in,
   output logic tap_out
);

   logic [DEPTH-1:0] stage;

   initial begin
      if (DEPTH < 2 || DEPTH > 32) begin
         $error("odtam_delay_line: DEPTH must be 2..32");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One flop per stage; input always flows so the line is warm at mode switch
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_stage
         always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) begin
               stage[i] <= 1'b0;
            end else begin
               stage[i] <= (i == 0) ? bit_in : stage[(i == 0) ? 0 : i-1];
            end
         end
      end
   endgenerate

   // Tap beyond the line saturates at the last stage
   assign tap_out = (int'(tap_in) < DEPTH) ? stage[tap_in] : stage[DEPTH-1];

endmodule

// ===== hw/odtam_timer.sv
// Loadable down counter that flags when a programmed delay has run out.
`timescale 1ns/1ps
module odtam_timer #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Control
   input wire logic load_in,
   input wire logic [WIDTH-1:0] value_in,
   output logic done_out
);

   logic [WIDTH-1:0] count;

   initial begin
      if (WIDTH < 1) begin
         $error("odtam_timer: WIDTH must be positive");
      end
   end

   // Counts the load cycle itself, so value N ends N cycles after the load
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count <= '0;
      end else if (load_in) begin
         count <= (value_in == '0) ? '0 : value_in - 1'b1;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   assign done_out = (count == '0) && !load_in;

endmodule

// ===== hw/odtam_top.sv
// Termination controller with synchronous and frozen-DLL asynchronous modes behind a Wishbone slave.
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module odtam_top import odtam_pkg::*; #(
   parameter int LINE_DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Memory pins from the controller
   input wire logic odt_in,
   input wire logic cke_in,
   input wire logic refresh_cmd_in,
   // Termination control
   output logic rtt_on_out,
   output logic async_mode_out,
   // Wishbone classic slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out
);

   initial begin
      if (LINE_DEPTH < 24 || LINE_DEPTH > 32) begin
         $error("odtam_top: LINE_DEPTH must be 24..32 to cover all write latencies");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   odtam_cfg_t cfg;
   odtam_state_t state;
   odtam_state_t next_state;
   logic odt_meta, odt_s;
   logic cke_meta, cke_s, cke_d;
   logic ref_meta, ref_s;
   logic cke_fall, cke_rise, freeze_en;
   logic [5:0] write_latency;
   logic [5:0] wl_eff;
   logic [4:0] sync_tap;
   logic [5:0] tap_wide;
   logic sync_bit;
   logic cpded_load, cpded_done;
   logic rfc_load, rfc_done;
   logic xpdll_load, xpdll_done;
   logic use_async;
   logic wb_req;
   logic [31:0] status_word;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the first flop feeds only the second
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         odt_meta <= 1'b0;
         odt_s <= 1'b0;
         cke_meta <= 1'b1; // Idle level, no false edge after reset
         cke_s <= 1'b1;
         ref_meta <= 1'b0;
         ref_s <= 1'b0;
      end else begin
         odt_meta <= odt_in;
         odt_s <= odt_meta;
         cke_meta <= cke_in;
         cke_s <= cke_meta;
         ref_meta <= refresh_cmd_in;
         ref_s <= ref_meta;
      end
   end

   // Previous clock-enable for edge detection; it resets to the pin's idle high
   // level so that releasing reset never looks like a power-down exit
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cke_d <= 1'b1;
      end else begin
         cke_d <= cke_s;
      end
   end

   assign cke_fall = cke_d && !cke_s;
   assign cke_rise = !cke_d && cke_s;

   // Frozen DLL only when running DLL-on and the freeze select bit is zero
   assign freeze_en = cfg.dll_on_mode && !cfg.dll_freeze_select_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronous path: write latency includes the additive latency
   assign write_latency = 6'(cfg.cas_write_latency) + 6'(cfg.additive_latency);
   // Clamp keeps the tap arithmetic from wrapping on a bad setting
   assign wl_eff = (write_latency < MIN_WRITE_LATENCY) ? MIN_WRITE_LATENCY : write_latency;
   // Input flop, tap and output flop add two, so tap is latency minus two more
   assign tap_wide = wl_eff - 6'(SYNC_LAT_OFFSET) - 6'(SYNC_LAT_OFFSET);
   // Saturate instead of wrapping: a tap past the line reads its last stage
   assign sync_tap = (tap_wide > 6'h1F) ? 5'h1F : tap_wide[4:0];

   odtam_delay_line #(
      .DEPTH(LINE_DEPTH)
   ) u_line (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .bit_in(odt_s),
      .tap_in(sync_tap),
      .tap_out(sync_bit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Period timers
   assign cpded_load = cke_fall;
   // Refresh commands are only decoded while clock enable is high
   assign rfc_load = ref_s && cke_s;
   assign xpdll_load = cke_rise;

   odtam_timer #(
      .WIDTH(8)
   ) u_cpded (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .load_in(cpded_load),
      .value_in(cfg.cpded_cycles),
      .done_out(cpded_done)
   );

   odtam_timer #(
      .WIDTH(8)
   ) u_rfc (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .load_in(rfc_load),
      .value_in(cfg.rfc_cycles),
      .done_out(rfc_done)
   );

   odtam_timer #(
      .WIDTH(8)
   ) u_xpdll (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .load_in(xpdll_load),
      .value_in(cfg.pd_exit_dll_delay),
      .done_out(xpdll_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode state machine. The lead of write latency minus one before a clock-enable
   // edge lies in the past; sync there and async there are both legal, so the
   // state before the edge simply keeps serving it.
   always_comb begin
      next_state = state;
      unique case (state)
         ST_SYNC: begin
            if (cke_fall && freeze_en) begin
               next_state = ST_ENTRY;
            end
         end
         ST_ENTRY: begin
            if (cke_rise) begin
               next_state = ST_EXIT;
            end else if (cpded_done && rfc_done) begin
               next_state = ST_ASYNC;
            end
         end
         ST_ASYNC: begin
            if (cke_rise) begin
               next_state = ST_EXIT;
            end
         end
         ST_EXIT: begin
            if (cke_fall && freeze_en) begin
               next_state = ST_ENTRY;
            end else if (xpdll_done) begin
               next_state = ST_SYNC;
            end
         end
         default: begin
            next_state = ST_SYNC;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= ST_SYNC;
      end else begin
         state <= next_state;
      end
   end

   // Transition periods resolve per the software pick; async region always async
   always_comb begin
      unique case (state)
         ST_ASYNC: use_async = 1'b1;
         ST_ENTRY, ST_EXIT: use_async = cfg.pick_async;
         default: use_async = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Termination output. Async path: one cycle from the sampled input, no
   // additive latency; at this rate that one cycle is 10 ns, longer than the 2 to 8.5 ns window.
   // Limitation: on return to sync, an input change younger than the latency
   // replays through the line once more.
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rtt_on_out <= 1'b0;
      end else if (use_async) begin
         rtt_on_out <= odt_s;
      end else begin
         rtt_on_out <= sync_bit;
      end
   end

   // Mode indicator
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         async_mode_out <= 1'b0;
      end else begin
         async_mode_out <= use_async;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone: one wait state, ack for one cycle, unmapped reads return zero
   // Ack blocks a second take while it stands, so each request answers once
   assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= wb_req;
      end
   end

   // Configuration writes honour byte lanes
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg.dll_on_mode <= RST_DLL_ON;
         cfg.dll_freeze_select_bit <= RST_FREEZE_SEL;
         cfg.pick_async <= RST_PICK_ASYNC;
         cfg.cas_write_latency <= RST_CWL;
         cfg.additive_latency <= RST_AL;
         cfg.cpded_cycles <= RST_CPDED;
         cfg.rfc_cycles <= RST_RFC;
         cfg.pd_exit_dll_delay <= RST_XPDLL;
      end else if (wb_req && wb_we_in) begin
         if (wb_adr_in == REG_CTRL && wb_sel_in[0]) begin
            cfg.dll_on_mode <= wb_dat_in[CTRL_DLL_ON_BIT];
            cfg.dll_freeze_select_bit <= wb_dat_in[CTRL_FREEZE_SEL_BIT];
            cfg.pick_async <= wb_dat_in[CTRL_PICK_ASYNC_BIT];
         end
         if (wb_adr_in == REG_LATENCY && wb_sel_in[0]) begin
            cfg.cas_write_latency <= wb_dat_in[LAT_CWL_LSB +: 5];
         end
         if (wb_adr_in == REG_LATENCY && wb_sel_in[1]) begin
            cfg.additive_latency <= wb_dat_in[LAT_AL_LSB +: 5];
         end
         if (wb_adr_in == REG_TIMING && wb_sel_in[0]) begin
            cfg.cpded_cycles <= wb_dat_in[TIM_CPDED_LSB +: 8];
         end
         if (wb_adr_in == REG_TIMING && wb_sel_in[1]) begin
            cfg.rfc_cycles <= wb_dat_in[TIM_RFC_LSB +: 8];
         end
         if (wb_adr_in == REG_TIMING && wb_sel_in[2]) begin
            cfg.pd_exit_dll_delay <= wb_dat_in[TIM_XPDLL_LSB +: 8];
         end
      end
   end

   // Live status word
   always_comb begin
      status_word = 32'h00000000;
      status_word[STAT_STATE_LSB +: 4] = state;
      status_word[STAT_RTT_BIT] = rtt_on_out;
      status_word[STAT_ODT_BIT] = odt_s;
      status_word[STAT_CKE_BIT] = cke_s;
      status_word[STAT_ASYNC_BIT] = async_mode_out;
   end

   // Read data registered with the ack
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wb_dat_out <= 32'h00000000;
      end else if (wb_req && !wb_we_in) begin
         unique case (wb_adr_in)
            REG_CTRL: wb_dat_out <= {29'h00000000, cfg.pick_async, cfg.dll_freeze_select_bit, cfg.dll_on_mode};
            REG_LATENCY: wb_dat_out <= {19'h00000, cfg.additive_latency, 3'h0, cfg.cas_write_latency};
            REG_TIMING: wb_dat_out <= {8'h00, cfg.pd_exit_dll_delay, cfg.rfc_cycles, cfg.cpded_cycles};
            REG_STATUS: wb_dat_out <= status_word;
            default: wb_dat_out <= 32'h00000000;
         endcase
      end
   end

endmodule

// ===== dv/odtam_props.sv
// Port-level checks for the termination mode controller.
`timescale 1ns/1ps
module odtam_props (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Memory pins
   input wire logic odt_in,
   input wire logic cke_in,
   input wire logic refresh_cmd_in,
   // Termination control
   input wire logic rtt_on_out,
   input wire logic async_mode_out,
   // Wishbone
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);

   // Run of clock-enable high samples; the exit delay may reach 255 cycles
   logic [8:0] cke_hi_run;
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cke_hi_run <= 9'h000;
      end else if (!cke_in) begin
         cke_hi_run <= 9'h000;
      end else if (cke_hi_run != 9'h1FF) begin
         cke_hi_run <= cke_hi_run + 9'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake, one answer per request; outputs quiet at reset release
   a_ack_single_pulse: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   a_ack_next_cycle: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("request not answered in one cycle");
   a_unmapped_read_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in[1:0] != 2'h0 |-> wb_dat_out == 32'h0)
      else $error("unmapped read returned data");
   a_read_data_holds: assert property ($fell(wb_ack_out) |-> $stable(wb_dat_out))
      else $error("read data moved after ack");
   a_reset_release_quiet: assert property ($rose(resetn_in) |-> !rtt_on_out && !async_mode_out)
      else $error("outputs active at reset release");

   ////////////////////////////////////////////////////////////////////////////
   // Mode and termination timing
   a_async_needs_pd: assert property ($rose(async_mode_out) |-> !$past(cke_in, 4))
      else $error("async mode without clock enable low");
   // Async path: three edges from pin to output, additive latency ignored
   a_async_tracks_odt: assert property ((async_mode_out && $changed(odt_in)) ##1 async_mode_out [*3] |-> rtt_on_out == $past(odt_in, 3))
      else $error("async termination delay wrong");
   a_sync_after_exit: assert property (cke_hi_run == 9'h108 |-> !async_mode_out)
      else $error("async mode held after exit");

   c_async_enter: cover property ($rose(async_mode_out));
   c_async_leave: cover property ($fell(async_mode_out));
   c_bus_write: cover property (wb_ack_out && wb_we_in);
endmodule

// ===== dv/odtam_ctrl_model.sv
// Behavioural memory controller driving termination and clock-enable pins.
`timescale 1ns/1ps
module odtam_ctrl_model (
   // Clock
   input wire logic clk_sys_in,
   // Pins toward the device
   output logic odt_out,
   output logic cke_out,
   output logic refresh_out
);
   // Powered up, termination off, no command
   initial begin
      odt_out = 1'b0;
      cke_out = 1'b1;
      refresh_out = 1'b0;
   end

   // Termination pin works in power-down too
   task automatic set_odt(input logic v);
      @(posedge clk_sys_in);
      odt_out <= v;
   endtask

   task automatic set_cke(input logic v);
      @(posedge clk_sys_in);
      cke_out <= v;
   endtask

   // Commands only while clock enable is high; no read or write ever issued
   task automatic pulse_refresh;
      @(posedge clk_sys_in);
      refresh_out <= cke_out;
      @(posedge clk_sys_in);
      refresh_out <= 1'b0;
   endtask
endmodule

// ===== dv/odtam_tb_top.sv
// Self-checking bench for the termination mode controller.
`timescale 1ns/1ps
module odtam_tb_top import odtam_pkg::*; ;
   logic clk_sys_in;
   logic resetn_in;
   logic odt_pin, cke_pin, refresh_pin, rtt_on_out, async_mode_out, wb_ack_out;
   logic wb_cyc, wb_stb, wb_we;
   logic [3:0] wb_adr, wb_sel;
   logic [31:0] wb_dat;
   logic [31:0] wb_dat_out, rd;
   logic [31:0] lat_reg [3] = '{32'h5, 32'h2, 32'h305};
   logic [31:0] no_frz [2] = '{32'h3, 32'h0};
   int lat_exp [3] = '{5, 5, 8};
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int lat;

   always #5 clk_sys_in = ~clk_sys_in;

   odtam_ctrl_model odtam_ctrl_model_i (.clk_sys_in(clk_sys_in), .odt_out(odt_pin), .cke_out(cke_pin),
      .refresh_out(refresh_pin));
   odtam_top #(.LINE_DEPTH(32)) odtam_top_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .odt_in(odt_pin),
      .cke_in(cke_pin), .refresh_cmd_in(refresh_pin), .rtt_on_out(rtt_on_out), .async_mode_out(async_mode_out),
      .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
      .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Run is well under a thousand cycles; ceiling of 8000 well above
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 8000) begin
         err_count++;
         $display("Error timeout expected end seen hang");
         final_report();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Classic cycle: hold everything until ack is sampled high
   task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      wb_sel <= sel;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 50);
      rd = wb_dat_out;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      chk("wb_ack", 1'b1, wb_ack_out);
   endtask

   task automatic wb_rd(input string name, input logic [3:0] adr, input logic [31:0] exp, input logic [31:0] m);
      wb_cycle(1'b0, adr, 32'h0, 4'hF);
      chk(name, exp, rd & m);
   endtask

   // Edges from pin change to termination change
   task automatic measure(input logic v, output int n);
      odtam_ctrl_model_i.set_odt(v);
      n = 0;
      do begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end while (rtt_on_out !== v && n < 40);
   endtask

   task automatic wait_async(input logic v, input int lim, output int n);
      n = 0;
      do begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end while (async_mode_out !== v && n < lim);
   endtask

   task automatic test_end(input string name);
      $display("Test %s finished, mismatches so far %0d", name, err_count);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys_in = 1'b0;
      resetn_in = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 4'h0;
      wb_sel = 4'h0;
      wb_dat = 32'h00000000;
      repeat (4) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      wb_rd("ctrl", REG_CTRL, 32'h3, 32'hFFFFFFFF);
      wb_rd("latency", REG_LATENCY, 32'h5, 32'hFFFFFFFF);
      wb_rd("timing", REG_TIMING, 32'h000A0B01, 32'hFFFFFFFF);
      wb_rd("status", REG_STATUS, 32'h41, 32'hFFFFFFFF);
      wb_rd("unmapped", 4'h1, 32'h0, 32'hFFFFFFFF);
      test_end("reset");
      // Write latency floor of five, additive latency adds on
      foreach (lat_reg[i]) begin
         wb_cycle(1'b1, REG_LATENCY, lat_reg[i], 4'hF);
         measure(1'b1, lat);
         chk("sync on delay", lat_exp[i], lat);
         measure(1'b0, lat);
         chk("sync off delay", lat_exp[i], lat);
      end
      test_end("sync");
      // Power-down without freeze keeps synchronous timing
      foreach (no_frz[i]) begin
         wb_cycle(1'b1, REG_CTRL, no_frz[i], 4'hF);
         odtam_ctrl_model_i.set_cke(1'b0);
         wait_async(1'b1, 20, lat);
         chk("async without freeze", 20, lat);
         measure(1'b1, lat);
         chk("pd sync delay", 8, lat);
         measure(1'b0, lat);
         odtam_ctrl_model_i.set_cke(1'b1);
         repeat (20) @(posedge clk_sys_in);
      end
      test_end("no_freeze");
      // Frozen power-down: async after entry, sync after exit
      wb_cycle(1'b1, REG_CTRL, 32'h1, 4'hF);
      wb_rd("ctrl freeze", REG_CTRL, 32'h1, 32'hFFFFFFFF);
      odtam_ctrl_model_i.set_cke(1'b0);
      wait_async(1'b1, 30, lat);
      chk("entry length", 5, lat);
      wb_rd("state async", REG_STATUS, {28'h0, ST_ASYNC}, 32'hF);
      measure(1'b1, lat);
      chk("async on delay", 3, lat);
      measure(1'b0, lat);
      chk("async off delay", 3, lat);
      odtam_ctrl_model_i.set_cke(1'b1);
      wait_async(1'b0, 30, lat);
      chk("exit leaves async", 4, lat);
      repeat (12) @(posedge clk_sys_in);
      wb_rd("state sync", REG_STATUS, {28'h0, ST_SYNC}, 32'hF);
      measure(1'b1, lat);
      chk("post exit delay", 8, lat);
      measure(1'b0, lat);
      test_end("freeze");
      // Refresh in progress stretches the entry period
      wb_cycle(1'b1, REG_TIMING, 32'h000A1401, 4'hF);
      odtam_ctrl_model_i.pulse_refresh();
      odtam_ctrl_model_i.set_cke(1'b0);
      repeat (2) @(posedge clk_sys_in);
      measure(1'b1, lat);
      chk("entry delay bounds", 1'b1, lat >= 3 && lat <= 8);
      wb_rd("state entry", REG_STATUS, {28'h0, ST_ENTRY}, 32'hF);
      wait_async(1'b1, 40, lat);
      chk("async after refresh", 1'b1, lat < 40);
      measure(1'b0, lat);
      chk("async off again", 3, lat);
      odtam_ctrl_model_i.set_cke(1'b1);
      repeat (20) @(posedge clk_sys_in);
      test_end("refresh");
      // Transition periods resolved as async; only the exit delay lane is written
      wb_cycle(1'b1, REG_TIMING, 32'h00060000, 4'h4);
      wb_rd("timing lane", REG_TIMING, 32'h00061401, 32'hFFFFFFFF);
      wb_cycle(1'b1, REG_CTRL, 32'h5, 4'hF);
      odtam_ctrl_model_i.set_cke(1'b0);
      wait_async(1'b1, 30, lat);
      chk("entry pick async", 4, lat);
      measure(1'b1, lat);
      chk("pick on delay", 3, lat);
      odtam_ctrl_model_i.set_cke(1'b1);
      wait_async(1'b0, 30, lat);
      chk("exit pick async", 10, lat);
      measure(1'b0, lat);
      chk("pick off sync", 8, lat);
      wb_cycle(1'b1, REG_CTRL, 32'h1, 4'hF);
      test_end("pick_async");
      // Very short power-down: overlapping periods settle to sync
      odtam_ctrl_model_i.set_cke(1'b0);
      odtam_ctrl_model_i.set_cke(1'b1);
      repeat (270) @(posedge clk_sys_in);
      wb_rd("short pd state", REG_STATUS, {28'h0, ST_SYNC}, 32'hF);
      measure(1'b1, lat);
      chk("short pd delay", 8, lat);
      test_end("short_pd");
      // Reset again in mid-run: configuration returns to its defaults
      @(posedge clk_sys_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      wb_rd("ctrl after reset", REG_CTRL, 32'h3, 32'hFFFFFFFF);
      wb_rd("latency after reset", REG_LATENCY, 32'h5, 32'hFFFFFFFF);
      test_end("reset_again");
      final_report();
   end
endmodule

bind odtam_top odtam_props odtam_props_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .odt_in(odt_in),
   .cke_in(cke_in), .refresh_cmd_in(refresh_cmd_in), .rtt_on_out(rtt_on_out), .async_mode_out(async_mode_out),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));
